/* pkg/osd_consts.svh */
// timing constants and reset values for the off-state diagnostics block
// assumes inclusion by bare name from the design files
`ifndef OSD_CONSTS_SVH
`define OSD_CONSTS_SVH

`define OSD_PREDIV_128 9'd128
`define OSD_PREDIV_192 9'd192
`define OSD_PREDIV_256 9'd256
`define OSD_FILT_TICKS 4'd9
`define OSD_TESTED_TICKS 4'd9
`define OSD_FLAGS_RST 3'h0

`endif

/* pkg/osd_pkg.sv */
// types shared by the off-state diagnostics design files
// assumes nothing beyond a SystemVerilog compiler
package osd_pkg;

  typedef struct packed {
    logic tested;
    logic short_ground_fault_flag;
    logic open_load_off_fault_flag;
  } osd_flags_t;

  typedef struct packed {
    logic open_load_raw;
    logic short_ground_raw;
  } osd_raw_t;

  typedef enum {
    OSD_ON,
    OSD_OFF_RUN,
    OSD_OFF_DONE
  } osd_phase_t;

endpackage : osd_pkg

/* hdl/osd_prediv.sv */
// predivider producing a one-cycle diagnostic tick enable
// assumes the select bits come from logic on the same clock
`timescale 1ns/100ps
`include "osd_consts.svh"
module osd_prediv (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // divider select
  input wire logic [1:0] sel_i,
  // tick enable
  output logic tick_o
);

  logic [8:0] cnt_q;
  logic [8:0] div;

  always_comb begin
    case (sel_i)
      2'h0: div = `OSD_PREDIV_128;
      2'h3: div = `OSD_PREDIV_256;
      default: div = `OSD_PREDIV_192;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 9'h0;
    end else if (cnt_q >= div - 9'h1) begin
      cnt_q <= 9'h0;
    end else begin
      cnt_q <= cnt_q + 9'h1;
    end
  end

  assign tick_o = (cnt_q == 9'h0);

endmodule : osd_prediv

/* hdl/osd_filter.sv */
// fault filter: raw high for the filter count of ticks sets the output,
// raw low drops it at once; clear restarts the count
// assumes raw input is already synchronised
`timescale 1ns/100ps
`include "osd_consts.svh"
module osd_filter (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // control
  input wire logic tick_i,
  input wire logic clr_i,
  input wire logic raw_i,
  // filtered result
  output logic filt_o
);

  logic [3:0] cnt_q;
  logic raw_q;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      raw_q <= 1'b0;
    end else begin
      raw_q <= raw_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 4'h0;
    end else if (clr_i || !raw_i || (raw_i && !raw_q)) begin
      cnt_q <= 4'h0;
    end else if (tick_i && cnt_q != `OSD_FILT_TICKS) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  assign filt_o = raw_i && (cnt_q == `OSD_FILT_TICKS);

endmodule : osd_filter

/* hdl/osd_core.sv */
// off-state diagnostics for four gate drive channels with over-voltage
// shutdown; assumes sense comparators and the over-voltage level arrive
// from pins, gate requests and fault read strobe come from local logic
`timescale 1ns/100ps
`include "osd_consts.svh"
module osd_core #(
  parameter int NCH = 4
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // configuration
  input wire logic timer_prescale_sel_hi_i,
  input wire logic timer_prescale_sel_lo_i,
  // gate requests from current control and gate pins
  input wire logic [NCH-1:0] gate_req_i,
  output logic [NCH-1:0] gate_drive_output_o,
  // raw comparator inputs, asynchronous
  input wire osd_pkg::osd_raw_t [NCH-1:0] raw_i,
  input wire logic overvoltage_raw_i,
  // fault register read strobe, one cycle
  input wire logic fault_read_i,
  // status
  output osd_pkg::osd_flags_t [NCH-1:0] flags_o,
  output logic [NCH-1:0] open_load_filtered_o,
  output logic [NCH-1:0] short_ground_filtered_o,
  output logic overvoltage_flag_o,
  output logic integrator_hold_o
);

  // ****************************************
  // input synchronisers and predivider
  // ****************************************
  logic [2:0] ov_sync_q;
  logic ov_q;
  logic [NCH-1:0] ol_s1_q, ol_s2_q, ol_s3_q, ol_q;
  logic [NCH-1:0] sg_s1_q, sg_s2_q, sg_s3_q, sg_q;
  logic tick;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ov_sync_q <= 3'h0;
      ov_q <= 1'b0;
    end else begin
      ov_sync_q <= {ov_sync_q[1:0], overvoltage_raw_i};
      if (ov_sync_q[1] == ov_sync_q[2]) begin
        ov_q <= ov_sync_q[2];
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ol_s1_q <= '0;
      ol_s2_q <= '0;
      ol_s3_q <= '0;
      ol_q <= '0;
      sg_s1_q <= '0;
      sg_s2_q <= '0;
      sg_s3_q <= '0;
      sg_q <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        ol_s1_q[i] <= raw_i[i].open_load_raw;
        sg_s1_q[i] <= raw_i[i].short_ground_raw;
        if (ol_s2_q[i] == ol_s3_q[i]) begin
          ol_q[i] <= ol_s3_q[i];
        end
        if (sg_s2_q[i] == sg_s3_q[i]) begin
          sg_q[i] <= sg_s3_q[i];
        end
      end
      ol_s2_q <= ol_s1_q;
      ol_s3_q <= ol_s2_q;
      sg_s2_q <= sg_s1_q;
      sg_s3_q <= sg_s2_q;
    end
  end

  osd_prediv u_prediv (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .sel_i({timer_prescale_sel_hi_i, timer_prescale_sel_lo_i}),
    .tick_o(tick)
  );

  // ****************************************
  // over-voltage response
  // ****************************************
  // only gates and integrator respond; nothing else is gated by ov_q
  assign overvoltage_flag_o = ov_q;
  assign integrator_hold_o = ov_q;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gate_drive_output_o <= '0;
    end else begin
      gate_drive_output_o <= ov_q ? '0 : gate_req_i;
    end
  end

  // ****************************************
  // per-channel diagnostics
  // ****************************************
  logic [NCH-1:0] gate_prev_q;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gate_prev_q <= '0;
    end else begin
      gate_prev_q <= gate_drive_output_o;
    end
  end

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic fell, rose, off, clr_filt;
    logic [3:0] tt_q;
    logic tt_exp, tt_exp_q, tt_hit;
    logic ol_f, sg_f;
    osd_pkg::osd_phase_t phase_q;
    osd_pkg::osd_flags_t fl_q;

    assign fell = gate_prev_q[c] && !gate_drive_output_o[c];
    assign rose = !gate_prev_q[c] && gate_drive_output_o[c];
    assign off = !gate_drive_output_o[c];
    assign clr_filt = fell || fault_read_i || !off;
    assign tt_exp = (phase_q == osd_pkg::OSD_OFF_DONE);
    // expiry counts once as an event, so a read while expired clears it
    assign tt_hit = tt_exp && !tt_exp_q;

    osd_filter u_ol (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .clr_i(clr_filt),
      .raw_i(ol_q[c]),
      .filt_o(ol_f)
    );

    osd_filter u_sg (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .clr_i(clr_filt),
      .raw_i(sg_q[c]),
      .filt_o(sg_f)
    );

    // filtered signals held low while gate is high
    assign open_load_filtered_o[c] = ol_f && off;
    assign short_ground_filtered_o[c] = sg_f && off;

    // tested timer, runs in every mode while the gate is low
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        phase_q <= osd_pkg::OSD_ON;
        tt_q <= 4'h0;
      end else begin
        case (phase_q)
          osd_pkg::OSD_ON: begin
            tt_q <= 4'h0;
            if (off) begin
              phase_q <= osd_pkg::OSD_OFF_RUN;
            end
          end
          osd_pkg::OSD_OFF_RUN: begin
            if (rose || !off) begin
              phase_q <= osd_pkg::OSD_ON;
              tt_q <= 4'h0;
            end else if (fault_read_i || fell) begin
              tt_q <= 4'h0;
            end else if (tick) begin
              if (tt_q == `OSD_TESTED_TICKS - 4'h1) begin
                phase_q <= osd_pkg::OSD_OFF_DONE;
              end
              tt_q <= tt_q + 4'h1;
            end
          end
          osd_pkg::OSD_OFF_DONE: begin
            if (!off) begin
              phase_q <= osd_pkg::OSD_ON;
              tt_q <= 4'h0;
            end else if (fault_read_i) begin
              phase_q <= osd_pkg::OSD_OFF_RUN;
              tt_q <= 4'h0;
            end
          end
          default: begin
            phase_q <= osd_pkg::OSD_ON;
            tt_q <= 4'h0;
          end
        endcase
      end
    end

    // delayed expiry level for the expiry event
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        tt_exp_q <= 1'b0;
      end else begin
        tt_exp_q <= tt_exp;
      end
    end

    // latched flags: a set in the read cycle wins over the clear
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        fl_q <= `OSD_FLAGS_RST;
      end else begin
        if (fault_read_i) begin
          fl_q <= `OSD_FLAGS_RST;
        end
        if (tt_hit) begin
          fl_q.tested <= 1'b1;
        end
        if (short_ground_filtered_o[c] && tt_exp) begin
          fl_q.short_ground_fault_flag <= 1'b1;
        end
        if (!short_ground_filtered_o[c] && open_load_filtered_o[c]) begin
          fl_q.open_load_off_fault_flag <= 1'b1;
        end
      end
    end

    assign flags_o[c] = fl_q;

    // ****************************************
    // checks
    // ****************************************
    sequence gate_fall_s;
      gate_prev_q[c] && !gate_drive_output_o[c];
    endsequence

    ovl_gate_low_a: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      ov_q |=> !gate_drive_output_o[c])
      else $error("gate high during over-voltage");

    fall_clear_a: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      gate_fall_s |=> tt_q == 4'h0 && !tt_exp)
      else $error("tested timer not cleared on gate fall");

    read_clears_a: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      fault_read_i && !tt_hit |=> !fl_q.tested)
      else $error("tested flag survived read");

    tested_set_a: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      tt_hit |=> fl_q.tested)
      else $error("tested flag not set on expiry");

    sg_flag_a: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      short_ground_filtered_o[c] && tt_exp |=> fl_q.short_ground_fault_flag)
      else $error("short flag not set");

    ol_flag_a: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      !short_ground_filtered_o[c] && open_load_filtered_o[c]
      |=> fl_q.open_load_off_fault_flag)
      else $error("open-load flag not set");

    flag_hold_a: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      fl_q.short_ground_fault_flag && !fault_read_i
      |=> fl_q.short_ground_fault_flag)
      else $error("short flag lost without read");

    ol_drop_a: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      !ol_q[c] |-> !open_load_filtered_o[c])
      else $error("open-load filtered high with raw low");

    sg_drop_a: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      !sg_q[c] |-> !short_ground_filtered_o[c])
      else $error("short filtered high with raw low");

    rise_clear_a: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      gate_drive_output_o[c] |=> !tt_exp)
      else $error("tested timer kept while gate high");
  end

  hold_ov_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    ov_sync_q[2] && ov_sync_q[1] |=> integrator_hold_o && overvoltage_flag_o)
    else $error("integrator not held in over-voltage");

endmodule : osd_core

/* test/osd_load_model.sv */
// model of the external gates and the load sense comparators
// assumes the bench picks which channels have an open or shorted load
`timescale 1ns/100ps
module osd_load_model (
  // gate pins
  input wire logic [3:0] gate_i,
  // load faults chosen by the bench
  input wire logic [3:0] open_i,
  input wire logic [3:0] short_i,
  // comparator levels
  output osd_pkg::osd_raw_t [3:0] raw_o
);
  // ****************
  // comparators
  // ****************
  // sensing only works with the gate off; a grounded load also
  // fails the open-load window comparator
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      raw_o[c].open_load_raw = !gate_i[c] && (open_i[c] || short_i[c]);
      raw_o[c].short_ground_raw = !gate_i[c] && short_i[c];
    end
  end
endmodule : osd_load_model

/* test/osd_core_tb_top.sv */
// self-checking bench for the off-state diagnostics core
// assumes the load model file and the design files are compiled first
`timescale 1ns/100ps
module osd_core_tb_top;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sel_hi = 1'b0;
  logic sel_lo = 1'b0;
  logic ov = 1'b0;
  logic rd = 1'b0;
  logic [3:0] gate_req = 4'hf;
  logic [3:0] open_f = 4'h0;
  logic [3:0] short_f = 4'h0;
  logic [3:0] gate_out;
  logic [3:0] olf;
  logic [3:0] sgf;
  logic ov_flag;
  logic hold;
  logic [19:0] stat;
  osd_pkg::osd_raw_t [3:0] raw;
  osd_pkg::osd_flags_t [3:0] flags;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;

  assign stat = {sgf, olf, flags};

  osd_core DUT (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .timer_prescale_sel_hi_i(sel_hi),
    .timer_prescale_sel_lo_i(sel_lo),
    .gate_req_i(gate_req),
    .gate_drive_output_o(gate_out),
    .raw_i(raw),
    .overvoltage_raw_i(ov),
    .fault_read_i(rd),
    .flags_o(flags),
    .open_load_filtered_o(olf),
    .short_ground_filtered_o(sgf),
    .overvoltage_flag_o(ov_flag),
    .integrator_hold_o(hold)
  );

  osd_load_model load (
    .gate_i(gate_out),
    .open_i(open_f),
    .short_i(short_f),
    .raw_o(raw)
  );

  // ****************
  // helpers
  // ****************
  always #2.5 sys_clk_i = ~sys_clk_i;

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      give_verdict();
    end
  end

  task give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  task chk(input logic [19:0] got, input logic [19:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task step(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask : step

  // counts cycles until a status bit rises, bounded
  task wait_bit(input int idx, input int lim);
    n = 0;
    while (stat[idx] !== 1'b1 && n < lim) begin
      step(1);
      n++;
    end
  endtask : wait_bit

  task in_rng(input int lo_b, input int hi_b);
    chk({19'h0, (n >= lo_b && n <= hi_b)}, 20'h1);
  endtask : in_rng

  task read_pulse();
    rd = 1'b1;
    step(1);
    rd = 1'b0;
    step(2);
  endtask : read_pulse

  // ****************
  // scenarios
  // ****************
  task t_reset();
    step(1);
    chk({stat[11:0], gate_out, ov_flag, hold, 2'h0}, 20'h0);
    step(15);
    rst_i = 1'b0;
    step(4);
    chk({gate_out, 16'h0}, 20'hf0000);
  endtask : t_reset

  // ch0 open, ch1 shorted, ch2 and ch3 healthy
  task t_faults();
    open_f = 4'h1;
    short_f = 4'h2;
    gate_req = 4'h0;
    wait_bit(8, 1400);
    in_rng(1000, 1300);
    wait_bit(0, 1500);
    wait_bit(4, 1500);
    chk(stat, {4'h2, 4'h3, 12'h935});
  endtask : t_faults

  task t_clear();
    open_f = 4'h0;
    short_f = 4'h0;
    step(7);
    chk(stat, {8'h0, 12'h935});
    read_pulse();
    chk(stat, 20'h0);
    wait_bit(8, 1400);
    in_rng(1000, 1300);
  endtask : t_clear

  task t_ov();
    gate_req = 4'hf;
    step(4);
    ov = 1'b1;
    step(7);
    chk({gate_out, ov_flag, hold, 14'h0}, 20'h0c000);
    ov = 1'b0;
    step(8);
    chk({gate_out, ov_flag, hold, 14'h0}, 20'hf0000);
  endtask : t_ov

  task t_prescale(input logic [1:0] s, input int lo_b, input int hi_b);
    gate_req = 4'hf;
    {sel_hi, sel_lo} = s;
    step(4);
    read_pulse();
    gate_req = 4'h0;
    wait_bit(8, hi_b + 200);
    in_rng(lo_b, hi_b);
  endtask : t_prescale

  initial begin
    t_reset();
    t_faults();
    t_clear();
    t_ov();
    t_prescale(2'h1, 1500, 1950);
    t_prescale(2'h2, 1500, 1950);
    t_prescale(2'h3, 2000, 2600);
    give_verdict();
  end
endmodule : osd_core_tb_top
